// [src/srwt_defines.svh]
// constants for the read/write turnaround block
`ifndef SRWT_DEFINES_SVH
`define SRWT_DEFINES_SVH
`define SRWT_BL_FIXED8 2'h0
`define SRWT_BL_OTF 2'h1
`define SRWT_BL_FIXED4 2'h2
`define SRWT_BURST8 5'h08
`define SRWT_BURST4 5'h04
`define SRWT_RTW_EXTRA 6'h01
`define SRWT_LAT_W 5
`define SRWT_CNT_W 6
`define SRWT_CAL_INIT_CYC 10'h200
`define SRWT_CAL_SHORT_CYC 10'h080
`endif

// [src/srwt_pkg.sv]
// shared types for the read/write turnaround block
package srwt_pkg;
  typedef enum logic [1:0] {
    SRWT_CMD_NOP,
    SRWT_CMD_READ,
    SRWT_CMD_WRITE
  } srwt_cmd_e;
  typedef logic [1:0] srwt_bg_t;
endpackage

// [src/srwt_link_if.sv]
// command link between controller and memory device
`timescale 1ns/1ps
interface srwt_link_if;
  srwt_pkg::srwt_cmd_e cmd;
  logic [1:0] bank_group;
  logic address_bit_twelve;
  modport ctrl (output cmd, output bank_group, output address_bit_twelve);
  modport dev (input cmd, input bank_group, input address_bit_twelve);
endinterface

// [src/srwt_device.sv]
// memory device end: decodes burst length of each command
`timescale 1ns/1ps
`include "srwt_defines.svh"
module srwt_device (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  srwt_link_if.dev LINK,
  input wire logic [1:0] MODE_BURST,
  input wire logic DLL_LOCKED,
  output logic RD_BURST8,
  output logic RD_VALID,
  output logic WR_VALID,
  output logic WR_BURST8,
  output logic TIMING_OK
);
  logic rd_b8;
  logic wr_b8;
  always_comb begin
    // otf uses bit twelve, high means eight beats
    rd_b8 = (MODE_BURST == `SRWT_BL_FIXED8) ||
            ((MODE_BURST == `SRWT_BL_OTF) && LINK.address_bit_twelve);
    // any otf write counts eight beats, even when chopped
    wr_b8 = MODE_BURST != `SRWT_BL_FIXED4;
  end
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      RD_VALID <= 1'b0;
      RD_BURST8 <= 1'b0;
      WR_VALID <= 1'b0;
      WR_BURST8 <= 1'b0;
    end else begin
      RD_VALID <= LINK.cmd == srwt_pkg::SRWT_CMD_READ;
      WR_VALID <= LINK.cmd == srwt_pkg::SRWT_CMD_WRITE;
      if (LINK.cmd == srwt_pkg::SRWT_CMD_READ) begin
        RD_BURST8 <= rd_b8;
      end
      if (LINK.cmd == srwt_pkg::SRWT_CMD_WRITE) begin
        WR_BURST8 <= wr_b8;
      end
    end
  end
  // output timing only promised with loop locked
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      TIMING_OK <= 1'b0;
    end else begin
      TIMING_OK <= DLL_LOCKED;
    end
  end
endmodule // srwt_device

// [src/srwt_ctrl.sv]
// controller end: spaces reads and writes by turnaround minimums
// What this block does
// - write after read waits read-to-write minimum
// - read after write waits write-to-read minimum
// - read burst eight unless chopped
// - write burst four only when chop fixed
// - allow extended calibration times for these
// - device reads eight beats for 00/otf-high
// - device timing valid only with locked loop
// - otf bit twelve low chop, high eight
// - write-to-read long same group, short otherwise
`timescale 1ns/1ps
`include "srwt_defines.svh"
module srwt_ctrl (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  srwt_link_if.ctrl LINK,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [1:0] REQ_BG,
  input wire logic REQ_BURST8,
  input wire logic [1:0] MODE_BURST,
  input wire logic [4:0] CAS_READ_LATENCY,
  input wire logic [4:0] CAS_WRITE_LATENCY,
  input wire logic [4:0] WRITE_PREAMBLE_TIME,
  input wire logic [4:0] WRITE_TO_READ_LONG,
  input wire logic [4:0] WRITE_TO_READ_SHORT,
  input wire logic CAL_INIT_REQ,
  output logic REQ_READY,
  output logic ISSUED
);

  // windows are 6 bits wide: latency sums must stay below 64
  typedef enum logic [1:0] {ST_IDLE, ST_CAL} srwt_st_e;
  srwt_st_e st_q;
  logic [9:0] cal_q;
  logic [5:0] rtw_q;
  logic [5:0] rtw_cnt;
  logic [5:0] rtw_load;
  logic [5:0] wtr_cnt;
  logic [5:0] wtr_long;
  logic [5:0] wtr_short;
  logic [3:0] wtr_free;
  logic [4:0] rbl_half;
  logic [4:0] wbl_half;
  logic rd_ok;
  logic wr_ok;
  logic fire;
  logic fire_rd;
  logic fire_wr;

  // chopped reads count four beats
  always_comb begin
    if ((MODE_BURST == `SRWT_BL_FIXED8) ||
        ((MODE_BURST == `SRWT_BL_OTF) && REQ_BURST8)) begin
      rbl_half = `SRWT_BURST8 >> 1;
    end else begin
      rbl_half = `SRWT_BURST4 >> 1;
    end
  end

  // an otf write counts eight even when chopped
  always_comb begin
    if (MODE_BURST == `SRWT_BL_FIXED4) begin
      wbl_half = `SRWT_BURST4 >> 1;
    end else begin
      wbl_half = `SRWT_BURST8 >> 1;
    end
  end

  // read latency minus write latency, half burst, one, preamble
  always_comb begin
    rtw_cnt = 6'(CAS_READ_LATENCY) - 6'(CAS_WRITE_LATENCY) +
      6'(rbl_half) + `SRWT_RTW_EXTRA + 6'(WRITE_PREAMBLE_TIME);
    // an older, longer read window must not be cut short
    if (rtw_q > rtw_cnt) begin
      rtw_load = rtw_q - 6'h01;
    end else begin
      rtw_load = rtw_cnt - 6'h01;
    end
  end

  // write latency plus half burst plus group delay
  always_comb begin
    wtr_cnt = 6'(CAS_WRITE_LATENCY) + 6'(wbl_half);
    wtr_long = wtr_cnt + 6'(WRITE_TO_READ_LONG);
    wtr_short = wtr_cnt + 6'(WRITE_TO_READ_SHORT);
  end

  // one window per bank group, long only in the written group
  for (genvar g = 0; g < 4; g++) begin : g_group
    logic [5:0] load;
    logic [5:0] left_q;
    always_comb begin
      if (REQ_BG == 2'(g)) begin
        load = wtr_long;
      end else begin
        load = wtr_short;
      end
    end
    // a later write elsewhere may not shorten this group's wait
    always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
        left_q <= 6'h00;
      end else if (fire_wr && load > left_q) begin
        left_q <= load - 6'h01;
      end else if (left_q != 6'h00) begin
        left_q <= left_q - 6'h01;
      end
    end
    assign wtr_free[g] = left_q == 6'h00;
  end

  // take a request only when its turnaround window is open
  always_comb begin
    rd_ok = wtr_free[REQ_BG];
    wr_ok = rtw_q == 6'h00;
    // ready high means the held request was taken on the last edge
    fire = REQ_VALID && !REQ_READY && (st_q == ST_IDLE) &&
      (REQ_WRITE ? wr_ok : rd_ok);
    fire_rd = fire && !REQ_WRITE;
    fire_wr = fire && REQ_WRITE;
  end

  // calibration window blocks commands
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_q <= ST_CAL;
      cal_q <= `SRWT_CAL_INIT_CYC;
    end else begin
      case (st_q)
        ST_CAL: begin
          cal_q <= cal_q - 10'h001;
          if (cal_q == 10'h001) begin
            st_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (CAL_INIT_REQ) begin
            st_q <= ST_CAL;
            cal_q <= `SRWT_CAL_SHORT_CYC;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // read window reloads on a read, else counts down
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rtw_q <= 6'h00;
    end else if (fire_rd) begin
      rtw_q <= rtw_load;
    end else if (rtw_q != 6'h00) begin
      rtw_q <= rtw_q - 6'h01;
    end
  end

  // issue strobe, same edge as the command
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ISSUED <= 1'b0;
    end else begin
      ISSUED <= fire;
    end
  end

  // one-cycle ready tells the requester to drop its request
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      REQ_READY <= 1'b0;
    end else begin
      REQ_READY <= fire;
    end
  end

  // command stands one cycle, nop otherwise
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      LINK.cmd <= srwt_pkg::SRWT_CMD_NOP;
    end else if (fire_wr) begin
      LINK.cmd <= srwt_pkg::SRWT_CMD_WRITE;
    end else if (fire_rd) begin
      LINK.cmd <= srwt_pkg::SRWT_CMD_READ;
    end else begin
      LINK.cmd <= srwt_pkg::SRWT_CMD_NOP;
    end
  end

  // group rides along with the command
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      LINK.bank_group <= 2'h0;
    end else if (fire) begin
      LINK.bank_group <= REQ_BG;
    end
  end

  // burst select for the device
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      LINK.address_bit_twelve <= 1'b0;
    end else if (fire) begin
      LINK.address_bit_twelve <= REQ_BURST8;
    end
  end
endmodule // srwt_ctrl

// [tb/srwt_link_props.sv]
// spacing checks on the command link
`timescale 1ns/1ps
module srwt_link_props (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input srwt_pkg::srwt_cmd_e cmd,
  input wire logic [1:0] bank_group,
  input wire logic address_bit_twelve
);
  // minimums below assume the latencies the bench drives
  wire idle = cmd == srwt_pkg::SRWT_CMD_NOP;
  wire rd = cmd == srwt_pkg::SRWT_CMD_READ;
  wire wr = cmd == srwt_pkg::SRWT_CMD_WRITE;
  logic [5:0] rd_q, wr_q;
  logic [9:0] up_q;
  logic [1:0] bg_q;
  always_ff @(posedge SYS_CLK) begin
    rd_q <= SYS_RST ? 6'h3f : rd ? 6'h01 : rd_q + 6'(rd_q != 6'h3f);
    wr_q <= SYS_RST ? 6'h3f : wr ? 6'h01 : wr_q + 6'(wr_q != 6'h3f);
    up_q <= SYS_RST ? 10'h000 : up_q + 10'(up_q != 10'h3ff);
    bg_q <= SYS_RST ? 2'h0 : wr ? bank_group : bg_q;
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  a_legal_cmd: assert property (idle || rd || wr)
    else $error("illegal command code");
  a_reset_nop: assert property (disable iff (1'b0) SYS_RST |=> idle)
    else $error("command during reset");
  a_cal_quiet: assert property (!idle |-> up_q > 10'h1fe)
    else $error("command during calibration");
  a_rd_to_wr: assert property (wr |-> rd_q > 6'h05)
    else $error("write too soon after read");
  a_wr_to_rd: assert property (rd |-> wr_q > 6'h0c)
    else $error("read too soon after write");
  a_wtr_long: assert property (rd && bank_group == bg_q |-> wr_q > 6'h0e)
    else $error("same group read too soon");
  a_rtw_hold: assert property (rd |=> !wr [*5])
    else $error("write inside read window");
  a_wtr_hold: assert property (wr |=> !rd [*8])
    else $error("read inside write window");
  a_one_issue: assert property (!idle |=> idle)
    else $error("command repeated on next cycle");
endmodule // srwt_link_props

// [tb/sdram_read_write_turnaround_bench.sv]
// bench: both link ends, request sequences with expected spacing
`timescale 1ns/1ps
module sdram_read_write_turnaround_bench;
  logic SYS_CLK = 0, SYS_RST = 1, v = 0, w = 0, b8 = 0, cal = 0, dll = 0;
  logic [1:0] bg = 0, mode = 1;
  logic rd8, rdv, wrv, wr8, tok, rdy, iss;
  int fails = 0, compares = 0;
  time tp = 0, tc = 0;
  srwt_link_if link ();
  srwt_ctrl u_srwt_ctrl (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .LINK(link.ctrl), .REQ_VALID(v), .REQ_WRITE(w), .REQ_BG(bg),
    .REQ_BURST8(b8), .MODE_BURST(mode), .CAS_READ_LATENCY(5'h0b),
    .CAS_WRITE_LATENCY(5'h09), .WRITE_PREAMBLE_TIME(5'h01),
    .WRITE_TO_READ_LONG(5'h04), .WRITE_TO_READ_SHORT(5'h02),
    .CAL_INIT_REQ(cal), .REQ_READY(rdy), .ISSUED(iss));
  srwt_device u_srwt_device (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .LINK(link.dev), .MODE_BURST(mode), .DLL_LOCKED(dll), .RD_BURST8(rd8),
    .RD_VALID(rdv), .WR_VALID(wrv), .WR_BURST8(wr8), .TIMING_OK(tok));
  srwt_link_props u_srwt_link_props (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .cmd(link.cmd), .bank_group(link.bank_group),
    .address_bit_twelve(link.address_bit_twelve));
  always #12.5 SYS_CLK = ~SYS_CLK;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // gap 0: spacing not checked; request held until ready
  task automatic req(input logic wr, input logic [1:0] g, input logic e8,
                     input logic [7:0] gap);
    int n;
    @(posedge SYS_CLK);
    v <= 1;
    w <= wr;
    bg <= g;
    b8 <= e8;
    for (n = 0; n < 1000 && rdy !== 1'b1; n++) @(posedge SYS_CLK);
    check(rdy, 1);
    check(iss, 1);
    v <= 0;
    if (gap != 0) check(8'(($time - tp) / 25), gap);
    tp = $time;
    #1;
    check({rdv, wrv}, {!wr, wr});
    if (!wr) check(rd8, mode == 0 || (mode == 1 && e8));
    else check(wr8, mode != 2);
  endtask
  task automatic stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge SYS_CLK);
    SYS_RST <= 0;
    dll <= 1;
    req(0, 0, 1, 0);
    req(1, 0, 1, 8);
    req(0, 0, 1, 17);
    req(0, 0, 0, 0);
    req(1, 1, 0, 6);
    req(0, 2, 1, 15);
    $display("on the fly test done");
    @(posedge SYS_CLK);
    mode <= 2;
    req(0, 2, 1, 0);
    req(1, 2, 1, 6);
    req(0, 2, 0, 15);
    $display("fixed chop test done");
    @(posedge SYS_CLK);
    mode <= 0;
    req(0, 3, 0, 0);
    req(1, 3, 0, 8);
    req(0, 0, 0, 15);
    $display("fixed eight test done");
    check(tok, 1);
    @(posedge SYS_CLK);
    dll <= 0;
    @(posedge SYS_CLK);
    #1;
    check(tok, 0);
    @(posedge SYS_CLK);
    cal <= 1;
    tc = $time;
    @(posedge SYS_CLK);
    cal <= 0;
    req(0, 0, 1, 0);
    check((tp - tc) / 25 > 128, 1);
    $display("lock and calibration test done");
    stop_test();
  end
  // whole run is under 800 cycles
  initial begin
    #200000;
    fails++;
    stop_test();
  end
endmodule // sdram_read_write_turnaround_bench
